/* File: src/lcc_pkg.sv */
// Functional notes
// [R01] Four cells, each a four-input lookup table plus one storage element.
// [R02] Function mux joins lookup outputs of cells 0/1 and 2/3 into five-input functions.
// [R03] Each cell has a carry mux; four carry bits per tile, chained upward.
// [R04] Arithmetic takes two cells per bit; neighbour XORs half-sum with carry.
// [R05] An extra initialisation stage supplies the chain's starting carry.
// [R06] Chained carry muxes give AND and OR cascaded wide decode.
// [R07] Storage data comes from the lookup output or from direct_in.
// [R08] Each cell has a direct_in feed-through and a combinational lookup output; o_x and o_direct_out are registered one bus clock later.
// [R09] Flop mode loads data on active edge with enable high, clear low.
// [R10] Latch mode: rising-active latch is transparent while clock low.
// [R11] Shared tile clock with per-element polarity; inversion absorbed.
// [R12] Enable is active high; unconnected means active; low holds output.
// [R13] Tile clear is active high, forces zero, can be disabled per element.
// [R14] Global clear zeroes every element at power-up and when driven.
// [R15] Global clear comes from a pin, optionally inverted, or internal node.
// [R16] Four line drivers, each plain buffer or three-state under shared enable.
// [R17] Three-state control high gives high impedance, low passes input.
// [R18] Each line driver reaches two horizontal and two vertical long lines.
// [R19] Long lines keep their last level when undriven.
// [R20] Clears take priority over clock, enable and latch transparency.
package lcc_pkg;

  // ***********************************************************
  // Sizes and bus map
  // ***********************************************************
  localparam int NUM_CELLS = 4;
  localparam int LUT_INPUTS = 4;
  localparam int LUT_BITS = 16;
  localparam int LINES_PER_DRV = 2;
  localparam int NUM_LINES = 8;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;
  localparam int SYNC_W = 2;

  localparam logic [4:0] OFF_LUT0 = 5'h00;
  localparam logic [4:0] OFF_LUT1 = 5'h04;
  localparam logic [4:0] OFF_LUT2 = 5'h08;
  localparam logic [4:0] OFF_LUT3 = 5'h0C;
  localparam logic [4:0] OFF_CELL_CFG = 5'h10;
  localparam logic [4:0] OFF_LINE_CFG = 5'h14;
  localparam logic [4:0] OFF_STATUS = 5'h18;

  // ***********************************************************
  // Reset values and field positions
  // ***********************************************************
  localparam logic [15:0] LUT_RESET = 16'h0000;
  localparam logic [31:0] CELL_CFG_RESET = 32'h00000000;
  localparam logic [31:0] CELL_CFG_MASK = 32'h1FFFFFFF;
  localparam logic [15:0] LINE_CFG_RESET = 16'h0000;
  localparam int STAT_Q_LSB = 0;
  localparam int STAT_X_LSB = 4;
  localparam int STAT_F5_LSB = 8;
  localparam int STAT_CARRY_LSB = 12;
  localparam int STAT_COUT_BIT = 16;

  // ***********************************************************
  // Carriers
  // ***********************************************************
  typedef struct packed {
    logic [2:0] reserved;
    logic gclr_inv;
    logic cascade_const;
    logic cascade;
    logic init_val;
    logic init_en;
    logic [3:0] ts_mode;
    logic [3:0] ce_dis;
    logic [3:0] clr_dis;
    logic [3:0] fall;
    logic [3:0] latch;
    logic [3:0] dsel_direct;
  } lcc_cell_cfg_type;

  typedef struct packed {
    logic [7:0] vconn;
    logic [7:0] hconn;
  } lcc_line_cfg_type;

endpackage : lcc_pkg

/* File: src/lcc_sync.sv */
`timescale 1ns/1ps
module lcc_sync (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Levels from outside the clock domain
  input wire logic [lcc_pkg::SYNC_W-1:0] i_async,
  output logic [lcc_pkg::SYNC_W-1:0] o_sync
);

  logic [lcc_pkg::SYNC_W-1:0] meta_reg;
  logic [lcc_pkg::SYNC_W-1:0] meta_next;
  logic [lcc_pkg::SYNC_W-1:0] sync_reg;
  logic [lcc_pkg::SYNC_W-1:0] sync_next;

  always_comb begin
    meta_next = i_async;
    sync_next = meta_reg;
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      meta_reg <= 2'h0;
      sync_reg <= 2'h0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign o_sync = sync_reg;

endmodule : lcc_sync

/* File: src/lcc_storage.sv */
`timescale 1ns/1ps
module lcc_storage (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Element controls
  input wire logic i_latch,
  input wire logic i_edge,
  input wire logic i_transparent,
  input wire logic i_ce,
  input wire logic i_clr,
  input wire logic i_d,
  // Stored value
  output logic o_q
);

  logic q_reg;
  logic q_next;

  always_comb begin
    q_next = q_reg;
    if (i_clr) begin
      q_next = 1'h0; // [R13] [R20]
    end else if (i_ce) begin
      if (i_latch ? i_transparent : i_edge) begin
        q_next = i_d; // [R09] [R10]
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      q_reg <= 1'h0; // [R14]
    end else begin
      q_reg <= q_next;
    end
  end

  assign o_q = q_reg;

endmodule : lcc_storage

/* File: src/lcc_tile.sv */
// Our own choices: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
module lcc_tile (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Register bus
  input wire logic [lcc_pkg::ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [lcc_pkg::DATA_W-1:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [lcc_pkg::DATA_W-1:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Cell inputs from routing
  input wire logic [15:0] i_lut_in,
  input wire logic [3:0] i_direct_in,
  input wire logic [1:0] i_f5_sel,
  input wire logic i_carry_in,
  // Shared storage controls
  input wire logic i_tile_clock,
  input wire logic i_tile_clock_enable,
  input wire logic i_tile_async_clear,
  input wire logic i_global_clear_net,
  input wire logic i_global_clear_node,
  // Line driver control
  input wire logic i_tile_output_enable,
  // Cell outputs
  output logic [3:0] o_q,
  output logic [3:0] o_x,
  output logic [3:0] o_direct_out,
  output logic [1:0] o_f5,
  output logic [3:0] o_cell_carry,
  output logic o_carry_out,
  // Long lines
  output logic [7:0] o_hline_out,
  output logic [7:0] o_hline_oe,
  output logic [7:0] o_vline_out,
  output logic [7:0] o_vline_oe
);

  // ***********************************************************
  // Configuration and bus state
  // ***********************************************************
  logic [15:0] lut_reg [lcc_pkg::NUM_CELLS];
  logic [15:0] lut_next [lcc_pkg::NUM_CELLS];
  lcc_pkg::lcc_cell_cfg_type cfg_reg;
  lcc_pkg::lcc_cell_cfg_type cfg_next;
  lcc_pkg::lcc_line_cfg_type line_cfg_reg;
  lcc_pkg::lcc_line_cfg_type line_cfg_next;
  logic wait_reg;
  logic wait_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [31:0] rd_mux;
  logic [31:0] status_word;
  logic bus_req;

  // ***********************************************************
  // Datapath state
  // ***********************************************************
  logic [3:0] x_reg;
  logic [3:0] x_next;
  logic [1:0] f5_reg;
  logic [1:0] f5_next;
  logic [3:0] dout_reg;
  logic [3:0] dout_next;
  logic [3:0] ccarry_reg;
  logic [3:0] ccarry_next;
  logic cout_reg;
  logic cout_next;
  logic [7:0] hout_reg;
  logic [7:0] hout_next;
  logic [7:0] hoe_reg;
  logic [7:0] hoe_next;
  logic [7:0] vout_reg;
  logic [7:0] vout_next;
  logic [7:0] voe_reg;
  logic [7:0] voe_next;
  logic clk_prev_reg;
  logic clk_prev_next;

  // ***********************************************************
  // Combinational cell nets
  // ***********************************************************
  logic [1:0] sync_out;
  logic tclk_s;
  logic gclr_s;
  logic gclr;
  logic rise;
  logic fall;
  logic [3:0] lut_out;
  logic [4:0] carry;
  logic [3:0] gen;
  logic [3:0] d_sel;
  logic [3:0] edge_act;
  logic [3:0] transp;
  logic [3:0] ce_eff;
  logic [3:0] clr_eff;
  logic [3:0] drv_on;
  logic [7:0] hoe_w;
  logic [7:0] voe_w;
  logic [7:0] lval_w;
  logic [3:0] q_w;

  function automatic logic [31:0] lcc_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                            input logic [3:0] be);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return res;
  endfunction : lcc_merge

  // ***********************************************************
  // Pin synchronisers
  // ***********************************************************
  // The tile clock is sampled, so its edges are only seen when each phase lasts one or more bus clocks.
  lcc_sync u_sync (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_async({i_global_clear_net, i_tile_clock}),
    .o_sync(sync_out)
  );

  assign tclk_s = sync_out[0];
  assign gclr_s = sync_out[1];
  assign gclr = (gclr_s ^ cfg_reg.gclr_inv) | i_global_clear_node; // [R15]
  assign rise = tclk_s & ~clk_prev_reg;
  assign fall = ~tclk_s & clk_prev_reg;
  assign carry[0] = cfg_reg.init_en ? cfg_reg.init_val : i_carry_in; // [R05]

  // ***********************************************************
  // Cells
  // ***********************************************************
  for (genvar i = 0; i < lcc_pkg::NUM_CELLS; i++) begin : g_cell
    assign lut_out[i] = lut_reg[i][i_lut_in[4*i +: 4]]; // [R01]
    assign gen[i] = cfg_reg.cascade ? cfg_reg.cascade_const : i_lut_in[4*i]; // [R04] [R06]
    assign carry[i+1] = lut_out[i] ? carry[i] : gen[i]; // [R03]
    assign d_sel[i] = cfg_reg.dsel_direct[i] ? i_direct_in[i] : lut_out[i]; // [R07]
    assign edge_act[i] = cfg_reg.fall[i] ? fall : rise; // [R11]
    assign transp[i] = cfg_reg.fall[i] ? tclk_s : ~tclk_s; // [R10]
    assign ce_eff[i] = i_tile_clock_enable | cfg_reg.ce_dis[i]; // [R12]
    assign clr_eff[i] = gclr | (i_tile_async_clear & ~cfg_reg.clr_dis[i]); // [R13] [R14]
    assign drv_on[i] = cfg_reg.ts_mode[i] ? ~i_tile_output_enable : 1'h1; // [R16] [R17]
    for (genvar k = 0; k < lcc_pkg::LINES_PER_DRV; k++) begin : g_line
      assign hoe_w[2*i+k] = drv_on[i] & line_cfg_reg.hconn[2*i+k]; // [R18]
      assign voe_w[2*i+k] = drv_on[i] & line_cfg_reg.vconn[2*i+k]; // [R18]
      assign lval_w[2*i+k] = lut_out[i];
    end
    lcc_storage u_store (
      .i_clk(i_clk),
      .i_resetn(i_resetn),
      .i_latch(cfg_reg.latch[i]),
      .i_edge(edge_act[i]),
      .i_transparent(transp[i]),
      .i_ce(ce_eff[i]),
      .i_clr(clr_eff[i]),
      .i_d(d_sel[i]),
      .o_q(q_w[i])
    );
  end

  // ***********************************************************
  // Datapath registers
  // ***********************************************************
  always_comb begin
    x_next = lut_out; // [R08]
    f5_next[0] = i_f5_sel[0] ? lut_out[1] : lut_out[0]; // [R02]
    f5_next[1] = i_f5_sel[1] ? lut_out[3] : lut_out[2]; // [R02]
    dout_next = i_direct_in; // [R08]
    ccarry_next = carry[3:0]; // [R04]
    cout_next = carry[4]; // [R03]
    hoe_next = hoe_w;
    voe_next = voe_w;
    hout_next = (hoe_w & lval_w) | (~hoe_w & hout_reg); // [R19]
    vout_next = (voe_w & lval_w) | (~voe_w & vout_reg); // [R19]
    clk_prev_next = tclk_s;
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      x_reg <= 4'h0;
      f5_reg <= 2'h0;
      dout_reg <= 4'h0;
      ccarry_reg <= 4'h0;
      cout_reg <= 1'h0;
      hout_reg <= 8'h00;
      hoe_reg <= 8'h00;
      vout_reg <= 8'h00;
      voe_reg <= 8'h00;
      clk_prev_reg <= 1'h0;
    end else begin
      x_reg <= x_next;
      f5_reg <= f5_next;
      dout_reg <= dout_next;
      ccarry_reg <= ccarry_next;
      cout_reg <= cout_next;
      hout_reg <= hout_next;
      hoe_reg <= hoe_next;
      vout_reg <= vout_next;
      voe_reg <= voe_next;
      clk_prev_reg <= clk_prev_next;
    end
  end

  // ***********************************************************
  // Register bus slave
  // ***********************************************************
  // One wait state: the first edge of a request latches read data, the second completes it.
  assign bus_req = i_avs_read | i_avs_write;

  always_comb begin
    status_word = 32'h00000000;
    status_word[lcc_pkg::STAT_Q_LSB +: 4] = q_w;
    status_word[lcc_pkg::STAT_X_LSB +: 4] = x_reg;
    status_word[lcc_pkg::STAT_F5_LSB +: 2] = f5_reg;
    status_word[lcc_pkg::STAT_CARRY_LSB +: 4] = ccarry_reg;
    status_word[lcc_pkg::STAT_COUT_BIT] = cout_reg;
    case (i_avs_address)
      lcc_pkg::OFF_LUT0: rd_mux = {16'h0000, lut_reg[0]};
      lcc_pkg::OFF_LUT1: rd_mux = {16'h0000, lut_reg[1]};
      lcc_pkg::OFF_LUT2: rd_mux = {16'h0000, lut_reg[2]};
      lcc_pkg::OFF_LUT3: rd_mux = {16'h0000, lut_reg[3]};
      lcc_pkg::OFF_CELL_CFG: rd_mux = cfg_reg;
      lcc_pkg::OFF_LINE_CFG: rd_mux = {16'h0000, line_cfg_reg};
      lcc_pkg::OFF_STATUS: rd_mux = status_word;
      default: rd_mux = 32'h00000000;
    endcase
  end

  always_comb begin
    logic [31:0] merged;
    merged = 32'h00000000;
    wait_next = 1'h1;
    rdata_next = rdata_reg;
    lut_next = lut_reg;
    cfg_next = cfg_reg;
    line_cfg_next = line_cfg_reg;
    if (bus_req && wait_reg) begin
      wait_next = 1'h0;
      rdata_next = i_avs_read ? rd_mux : 32'h00000000;
    end else if (i_avs_write) begin
      merged = lcc_merge(rd_mux, i_avs_writedata, i_avs_byteenable);
      case (i_avs_address)
        lcc_pkg::OFF_LUT0: lut_next[0] = merged[15:0];
        lcc_pkg::OFF_LUT1: lut_next[1] = merged[15:0];
        lcc_pkg::OFF_LUT2: lut_next[2] = merged[15:0];
        lcc_pkg::OFF_LUT3: lut_next[3] = merged[15:0];
        lcc_pkg::OFF_CELL_CFG: cfg_next = merged & lcc_pkg::CELL_CFG_MASK;
        lcc_pkg::OFF_LINE_CFG: line_cfg_next = merged[15:0];
        default: merged = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      wait_reg <= 1'h1;
      rdata_reg <= 32'h00000000;
      lut_reg <= '{default: lcc_pkg::LUT_RESET};
      cfg_reg <= lcc_pkg::CELL_CFG_RESET;
      line_cfg_reg <= lcc_pkg::LINE_CFG_RESET;
    end else begin
      wait_reg <= wait_next;
      rdata_reg <= rdata_next;
      lut_reg <= lut_next;
      cfg_reg <= cfg_next;
      line_cfg_reg <= line_cfg_next;
    end
  end

  // ***********************************************************
  // Outputs
  // ***********************************************************
  assign o_avs_readdata = rdata_reg;
  assign o_avs_waitrequest = wait_reg;
  assign o_q = q_w;
  assign o_x = x_reg;
  assign o_direct_out = dout_reg;
  assign o_f5 = f5_reg;
  assign o_cell_carry = ccarry_reg;
  assign o_carry_out = cout_reg;
  assign o_hline_out = hout_reg;
  assign o_hline_oe = hoe_reg;
  assign o_vline_out = vout_reg;
  assign o_vline_oe = voe_reg;

  // ***********************************************************
  // Checks
  // ***********************************************************
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);

  sequence seq_req_open;
    bus_req && wait_reg;
  endsequence

  sequence seq_req_done;
    ##1 !o_avs_waitrequest ##1 o_avs_waitrequest;
  endsequence

  chk_bus_one_wait: assert property (seq_req_open |-> seq_req_done)
    else $error("Bus answer not given after exactly one wait state.");

  chk_clear_forces_zero: assert property ( // [R13]
    (i_tile_async_clear && !cfg_reg.clr_dis[0]) |=> (o_q[0] == 1'h0))
    else $error("Tile clear did not zero element 0.");

  chk_global_zero: assert property ( // [R14]
    gclr |=> (o_q == 4'h0))
    else $error("Global clear did not zero all elements.");

  chk_enable_holds: assert property ( // [R12]
    (!ce_eff[1] && !clr_eff[1]) |=> $stable(o_q[1]))
    else $error("Element 1 changed with enable low.");

  chk_flop_capture: assert property ( // [R09]
    (!cfg_reg.latch[0] && edge_act[0] && ce_eff[0] && !clr_eff[0]) |=> (o_q[0] == $past(d_sel[0])))
    else $error("Flop did not take data on its active edge.");

  chk_flop_between: assert property ( // [R09]
    (!cfg_reg.latch[2] && !edge_act[2] && !clr_eff[2]) |=> $stable(o_q[2]))
    else $error("Flop changed between active edges.");

  chk_latch_opaque: assert property ( // [R10]
    (cfg_reg.latch[3] && !transp[3] && !clr_eff[3]) |=> $stable(o_q[3]))
    else $error("Latch changed while opaque.");

  chk_f5_select: assert property ( // [R02]
    1'h1 |=> (o_f5[0] == ($past(i_f5_sel[0]) ? $past(lut_out[1]) : $past(lut_out[0]))))
    else $error("Five-input mux picked the wrong lookup output.");

  chk_carry_pass: assert property ( // [R03]
    ((lut_out == 4'hF) && !cfg_reg.init_en) |=> (o_carry_out == $past(i_carry_in)))
    else $error("Carry did not pass through an all-propagate tile.");

  chk_line_tristate: assert property ( // [R17]
    (cfg_reg.ts_mode[0] && i_tile_output_enable) |=> (o_hline_oe[1:0] == 2'h0 && o_vline_oe[1:0] == 2'h0))
    else $error("Line driver 0 still driving with three-state control high.");

  chk_line_keeper: assert property ( // [R19]
    !o_hline_oe[4] |-> (o_hline_out[4] == $past(o_hline_out[4])))
    else $error("Undriven line 4 lost its level.");

  chk_feed_through: assert property ( // [R08]
    1'h1 |=> (o_direct_out == $past(i_direct_in)))
    else $error("Feed-through did not follow direct input.");

endmodule : lcc_tile

/* File: dv/lcc_fabric_model.sv */
`timescale 1ns/1ps
module lcc_fabric_model (
  // Clock
  input wire logic i_clk,
  // Tile outputs seen by the neighbour column
  input wire logic [3:0] i_x,
  input wire logic [3:0] i_cell_carry,
  input wire logic [7:0] i_line_out,
  input wire logic [7:0] i_line_oe,
  // Neighbour results
  output logic [3:0] o_sum,
  output logic [7:0] o_line
);
  // ********
  // Sum column and long-line keepers
  // ********
  logic [7:0] keep_reg = 8'h00;
  logic [7:0] keep_next;
  // The neighbour column finishes each bit from the half-sum and its carry.
  assign o_sum = i_x ^ i_cell_carry;
  // A weak keeper loses to any driver, so an undriven line shows its last level.
  always_comb begin
    keep_next = (i_line_oe & i_line_out) | (~i_line_oe & keep_reg);
  end
  always_ff @(posedge i_clk) begin
    keep_reg <= keep_next;
  end
  assign o_line = keep_next;
endmodule : lcc_fabric_model

/* File: dv/lcc_tile_tb_top.sv */
`timescale 1ns/1ps
module lcc_tile_tb_top;
  // ********
  // Bench signals
  // ********
  logic clk = 1'h0;
  logic resetn = 1'h0;
  logic [4:0] addr = 5'h00;
  logic rd = 1'h0;
  logic wr = 1'h0;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] be = 4'hF;
  logic [15:0] lut_in = 16'h0000;
  logic [3:0] din = 4'h0;
  logic [1:0] f5_sel = 2'h0;
  logic cin = 1'h0;
  logic tclk = 1'h0;
  logic tce = 1'h1;
  logic tclr = 1'h0;
  logic gnet = 1'h0;
  logic gnode = 1'h0;
  logic toe = 1'h0;
  logic [31:0] rdata, got;
  logic waitreq, cout;
  logic [3:0] q, x, dout, ccar, sum, ex, av, bv;
  logic [1:0] f5;
  logic [4:0] ch, s;
  logic [7:0] hout, hoe, vout, voe, vline;
  logic [15:0] lutv [4];
  logic [15:0] vecs [4] = '{16'h0000, 16'hFFFF, 16'h1E5A, 16'hC37B};
  logic [8:0] adds [4] = '{9'h0F1, 9'h15A, 9'h079, 9'h100};
  logic [32:0] casc [4] = '{33'h1_8000_FFFF, 33'h0_8000_FFFE, 33'h1_0001_0000, 33'h0_0001_0100};
  lcc_pkg::lcc_cell_cfg_type cfg;
  int num_errors = 0;
  int checks = 0;

  always #25 clk = ~clk;

  lcc_tile dut (
    .i_clk(clk), .i_resetn(resetn),
    .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wdata), .i_avs_byteenable(be),
    .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq),
    .i_lut_in(lut_in), .i_direct_in(din), .i_f5_sel(f5_sel), .i_carry_in(cin),
    .i_tile_clock(tclk), .i_tile_clock_enable(tce), .i_tile_async_clear(tclr),
    .i_global_clear_net(gnet), .i_global_clear_node(gnode), .i_tile_output_enable(toe),
    .o_q(q), .o_x(x), .o_direct_out(dout), .o_f5(f5), .o_cell_carry(ccar), .o_carry_out(cout),
    .o_hline_out(hout), .o_hline_oe(hoe), .o_vline_out(vout), .o_vline_oe(voe)
  );

  lcc_fabric_model far_side (
    .i_clk(clk), .i_x(x), .i_cell_carry(ccar), .i_line_out(vout), .i_line_oe(voe),
    .o_sum(sum), .o_line(vline)
  );

  // ********
  // Helpers
  // ********
  function automatic logic [15:0] spread(input logic [3:0] a, input logic [3:0] b);
    logic [15:0] r;
    r = 16'h0000;
    for (int i = 0; i < 4; i++) r[4 * i +: 2] = {b[i], a[i]};
    return r;
  endfunction : spread

  function automatic logic [4:0] chain(input logic [3:0] p, input logic [3:0] g, input logic c0);
    logic [4:0] c;
    c[0] = c0;
    for (int i = 0; i < 4; i++) c[i + 1] = p[i] ? c[i] : g[i];
    return c;
  endfunction : chain

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // The request stands until waitrequest is sampled low; only then is it dropped.
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d, input logic [3:0] b);
    addr <= a;
    wr <= w;
    rd <= ~w;
    wdata <= d;
    be <= b;
    do begin
      @(posedge clk);
    end while (waitreq !== 1'h0);
    got = rdata;
    wr <= 1'h0;
    rd <= 1'h0;
    @(posedge clk);
  endtask : bus

  task automatic rd_chk(input string name, input logic [4:0] a, input logic [31:0] exp);
    bus(1'h0, a, 32'h00000000, 4'hF);
    check(name, got, exp);
  endtask : rd_chk

  task automatic set_luts(input logic [15:0] v0, input logic [15:0] v1, input logic [15:0] v2,
                          input logic [15:0] v3);
    lutv = '{v0, v1, v2, v3};
    for (int i = 0; i < 4; i++) bus(1'h1, 5'(4 * i), {16'h0000, lutv[i]}, 4'hF);
  endtask : set_luts

  task automatic set_cfg();
    bus(1'h1, lcc_pkg::OFF_CELL_CFG, cfg, 4'hF);
  endtask : set_cfg

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  // Six edges cover the two-flop tile clock path plus the storage update.
  task automatic q_step(input string name, input logic [3:0] exp);
    tick(6);
    check(name, {28'h0000000, q}, {28'h0000000, exp});
  endtask : q_step

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test

  // ********
  // Tests
  // ********
  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    $display("Watchdog expired");
    finish_test();
  end

  initial begin
    cfg = '0;
    tick(16);
    resetn <= 1'h1;
    tick(1);
    for (int i = 0; i < 8; i++) rd_chk("reset value", 5'(4 * i), 32'h00000000);
    bus(1'h1, lcc_pkg::OFF_LUT0, 32'hFFFF1234, 4'hF);
    rd_chk("lut0", lcc_pkg::OFF_LUT0, 32'h00001234);
    bus(1'h1, lcc_pkg::OFF_LUT0, 32'h0000AB00, 4'h2);
    rd_chk("lut0 byte", lcc_pkg::OFF_LUT0, 32'h0000AB34);
    bus(1'h1, lcc_pkg::OFF_CELL_CFG, 32'hFFFFFFFF, 4'hF);
    rd_chk("cell cfg", lcc_pkg::OFF_CELL_CFG, lcc_pkg::CELL_CFG_MASK);
    bus(1'h1, 5'h1C, 32'hFFFFFFFF, 4'hF);
    rd_chk("unmapped", 5'h1C, 32'h00000000);
    rd_chk("misaligned", 5'h01, 32'h00000000);
    set_cfg();
    $display("Test registers finished");
    set_luts(16'hA5C3, 16'h0FF0, 16'h1234, 16'h8001);
    for (int k = 0; k < 4; k++) begin
      lut_in <= vecs[k];
      f5_sel <= 2'(k);
      din <= 4'(k * 5);
      tick(2);
      for (int c = 0; c < 4; c++) ex[c] = lutv[c][vecs[k][4 * c +: 4]];
      check("lut out", {28'h0000000, x}, {28'h0000000, ex});
      check("f5 out", {30'h00000000, f5}, {30'h00000000, k[1] ? ex[3] : ex[2], k[0] ? ex[1] : ex[0]});
      check("direct out", {28'h0000000, dout}, 32'(k * 5));
    end
    $display("Test functions finished");
    set_luts(16'h6666, 16'h6666, 16'h6666, 16'h6666);
    for (int k = 0; k < 4; k++) begin
      av = adds[k][7:4];
      bv = adds[k][3:0];
      cin <= adds[k][8];
      lut_in <= spread(av, bv);
      tick(2);
      ch = chain(av ^ bv, av, adds[k][8]);
      s = av + bv + adds[k][8];
      check("cell carry", {28'h0000000, ccar}, {28'h0000000, ch[3:0]});
      check("carry out", {31'h00000000, cout}, {31'h00000000, s[4]});
      check("sum", {28'h0000000, sum}, {28'h0000000, s[3:0]});
    end
    cfg.init_en = 1'h1;
    cfg.init_val = 1'h1;
    set_cfg();
    cin <= 1'h0;
    lut_in <= spread(4'hF, 4'h0);
    tick(2);
    check("init carry", {31'h00000000, ccar[0]}, 32'h00000001);
    check("init sum", {27'h0000000, cout, sum}, 32'h00000010);
    cfg.cascade = 1'h1;
    set_cfg();
    for (int k = 0; k < 4; k++) begin
      set_luts(casc[k][31:16], casc[k][31:16], casc[k][31:16], casc[k][31:16]);
      lut_in <= casc[k][15:0];
      tick(2);
      check("cascade", {31'h00000000, cout}, {31'h00000000, casc[k][32]});
    end
    cfg.init_val = 1'h0;
    cfg.cascade_const = 1'h1;
    set_cfg();
    lut_in <= 16'h0000;
    tick(2);
    check("or cascade match", {31'h00000000, cout}, 32'h00000000);
    lut_in <= 16'h0100;
    tick(2);
    check("or cascade miss", {31'h00000000, cout}, 32'h00000001);
    $display("Test carry finished");
    cfg = '0;
    cfg.dsel_direct = 4'hC;
    cfg.latch = 4'h8;
    cfg.fall = 4'h2;
    cfg.clr_dis = 4'h4;
    set_cfg();
    set_luts(16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF);
    din <= 4'hF;
    q_step("latch open", 4'h8);
    tclk <= 1'h1;
    q_step("rising edge", 4'hD);
    din <= 4'h0;
    q_step("latch hold", 4'hD);
    tclk <= 1'h0;
    q_step("falling edge", 4'h7);
    tce <= 1'h0;
    tclk <= 1'h1;
    q_step("enable low rise", 4'h7);
    din <= 4'hF;
    tclk <= 1'h0;
    q_step("enable low fall", 4'h7);
    cfg.ce_dis = 4'h8;
    set_cfg();
    q_step("enable forced", 4'hF);
    tclr <= 1'h1;
    q_step("tile clear", 4'h4);
    tclr <= 1'h0;
    q_step("clear off", 4'hC);
    gnode <= 1'h1;
    q_step("global node", 4'h0);
    gnode <= 1'h0;
    q_step("global off", 4'h8);
    gnet <= 1'h1;
    q_step("global pin", 4'h0);
    gnet <= 1'h0;
    q_step("pin off", 4'h8);
    cfg.gclr_inv = 1'h1;
    set_cfg();
    q_step("pin inverted", 4'h0);
    $display("Test storage finished");
    cfg = '0;
    cfg.ts_mode = 4'h3;
    set_cfg();
    bus(1'h1, lcc_pkg::OFF_LINE_CFG, 32'h0000FF55, 4'hF);
    rd_chk("line cfg", lcc_pkg::OFF_LINE_CFG, 32'h0000FF55);
    tick(2);
    check("h oe", {24'h000000, hoe}, 32'h00000055);
    check("h out", {24'h000000, hout & hoe}, 32'h00000055);
    check("v line", {24'h000000, vline}, 32'h000000FF);
    toe <= 1'h1;
    tick(2);
    check("h oe ts", {24'h000000, hoe}, 32'h00000050);
    check("v oe ts", {24'h000000, voe}, 32'h000000F0);
    set_luts(16'h0000, 16'h0000, 16'hFFFF, 16'hFFFF);
    tick(2);
    check("v keep", {24'h000000, vline}, 32'h000000FF);
    toe <= 1'h0;
    tick(2);
    check("v drive", {24'h000000, vline}, 32'h000000F0);
    rd_chk("status", lcc_pkg::OFF_STATUS, 32'h000002C0);
    $display("Test line drivers finished");
    finish_test();
  end
endmodule : lcc_tile_tb_top
